/* File: rtl/pse_exec.sv */
// Purpose: Executes privileged system operations of a controller processor
// Assumes: Memory answers a read with mem_rvalid one or more cycles later
// Notes: Logic result bit is an input only; nothing here changes it
//
// What this block does
// RULE1: Two 16-bit accumulators, moved as whole words.
// RULE2: Indirect load and store ignore the logic result bit.
// RULE3: Indirect address is the primary accumulator at operation start.
// RULE4: Load with select 0 replaces primary accumulator with addressed word.
// RULE5: Select 0 means primary, select 2 means secondary accumulator.
// RULE6: Indirect store writes selected accumulator to address in primary.
// RULE7: Block copy ignores logic result bit; lengths up to 255 bytes.
// RULE8: Copy source is secondary accumulator, destination primary accumulator.
// RULE9: Copy starts at highest addresses and decrements both per byte.
// RULE10: Copy overwrites every destination byte with source byte.
// RULE11: System data word 96 holds scan time in 10 ms; stores update it.
// RULE12: Stores and copies have no access checking or protection.
// RULE13: Constant add adds signed byte or word immediate to primary.
// RULE14: Constant add ignores and keeps logic result bit and condition codes.
// RULE15: Add overflow keeps low 16 bits; secondary accumulator untouched.
// RULE16: Swap exchanges accumulators, ignoring logic result, codes unchanged.
// RULE17: Immediate stop forces stop state regardless of logic result bit.
// RULE18: Stop ends execution at once; left by mode selector or start.
// RULE19: Byte immediate is sign-extended to 16 bits before adding.
module pse_exec
  import pse_pkg::*;
#(
  parameter int AW = PSE_WORD_W,
  parameter int DW = PSE_WORD_W
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic op_valid,
  input wire pse_op_t op_code,
  input wire logic [DW-1:0] op_param,
  input wire logic logic_result_bit,
  input wire logic mode_run_pin,
  input wire logic external_start_command,
  output logic op_ready_r,
  output logic op_done_r,
  output logic mem_req_r,
  output logic mem_we_r,
  output logic mem_byte_r,
  output logic [AW-1:0] mem_addr_r,
  output logic [DW-1:0] mem_wdata_r,
  input wire logic mem_rvalid,
  input wire logic [DW-1:0] mem_rdata,
  output logic [DW-1:0] primary_accumulator_r,
  output logic [DW-1:0] secondary_accumulator_r,
  output logic stopped_r,
  output logic [DW-1:0] scan_time_r
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic mode_s1_r;
  logic mode_s2_r;
  logic start_s1_r;
  logic start_s2_r;
  logic mode_prev_r;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_s1_r <= 1'b0;
      mode_s2_r <= 1'b0;
      start_s1_r <= 1'b0;
      start_s2_r <= 1'b0;
      mode_prev_r <= 1'b0;
    end
    else
    begin
      mode_s1_r <= mode_run_pin;
      mode_s2_r <= mode_s1_r;
      start_s1_r <= external_start_command;
      start_s2_r <= start_s1_r;
      mode_prev_r <= mode_s2_r;
    end
  end

  wire mode_rise = mode_s2_r & ~mode_prev_r;
  wire restart = mode_rise | start_s2_r;

  ////////////////////////////////////////////////////////////////////////
  // Decode

  function automatic logic [DW-1:0] sext_byte(input logic [7:0] b);
    sext_byte = {{(DW-8){b[7]}}, b};
  endfunction : sext_byte

  pse_state_t state_r;
  pse_state_t state_nxt;
  logic [AW-1:0] src_r;
  logic [AW-1:0] dst_r;
  logic [PSE_LEN_W-1:0] cnt_r;
  logic load_sel_sec_r;

  wire idle = state_r == PSE_ST_IDLE;
  wire take = idle & op_valid;
  wire [1:0] sel = op_param[1:0];
  wire sel_sec = sel == PSE_SEL_SECONDARY;
  wire [DW-1:0] sel_acc = sel_sec ? secondary_accumulator_r : primary_accumulator_r;
  wire [DW-1:0] add_imm = (op_code == PSE_OP_ADD_BYTE) ? sext_byte(op_param[7:0]) : op_param;
  wire [DW-1:0] add_sum = primary_accumulator_r + add_imm;
  wire [PSE_LEN_W-1:0] len = op_param[PSE_LEN_W-1:0];
  wire sys_wr = take & (op_code == PSE_OP_SYS_STORE);
  wire copy_last = cnt_r == 8'h01;

  ////////////////////////////////////////////////////////////////////////
  // State machine

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      PSE_ST_IDLE:
      begin
        if (op_valid)
        begin
          unique case (op_code)
            PSE_OP_LOAD_IND: state_nxt = PSE_ST_LOAD_WAIT;
            PSE_OP_BLOCK_COPY: state_nxt = (len == 8'h00) ? PSE_ST_IDLE : PSE_ST_COPY_READ;
            PSE_OP_STOP: state_nxt = PSE_ST_STOPPED; // see RULE17
            default: state_nxt = PSE_ST_IDLE;
          endcase
        end
      end
      PSE_ST_LOAD_WAIT:
      begin
        if (mem_rvalid)
        begin
          state_nxt = PSE_ST_IDLE;
        end
      end
      PSE_ST_COPY_READ: state_nxt = PSE_ST_COPY_WAIT;
      PSE_ST_COPY_WAIT:
      begin
        if (mem_rvalid)
        begin
          state_nxt = copy_last ? PSE_ST_IDLE : PSE_ST_COPY_READ; // see RULE9
        end
      end
      PSE_ST_STOPPED:
      begin
        if (restart)
        begin
          state_nxt = PSE_ST_IDLE; // see RULE18
        end
      end
      default: state_nxt = PSE_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= PSE_ST_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Accumulators; logic result bit is never consulted (see RULE2)

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      primary_accumulator_r <= PSE_ACC_RST;
      secondary_accumulator_r <= PSE_ACC_RST;
      load_sel_sec_r <= 1'b0;
    end
    else if (take)
    begin
      load_sel_sec_r <= sel_sec; // see RULE5
      if (op_code == PSE_OP_ADD_BYTE || op_code == PSE_OP_ADD_WORD)
      begin
        primary_accumulator_r <= add_sum; // see RULE13 see RULE14 see RULE15 see RULE19
      end
      else if (op_code == PSE_OP_SWAP)
      begin
        primary_accumulator_r <= secondary_accumulator_r; // see RULE16
        secondary_accumulator_r <= primary_accumulator_r; // see RULE16
      end
    end
    else if (state_r == PSE_ST_LOAD_WAIT && mem_rvalid)
    begin
      if (load_sel_sec_r)
      begin
        secondary_accumulator_r <= mem_rdata; // see RULE1
      end
      else
      begin
        primary_accumulator_r <= mem_rdata; // see RULE4
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Memory port; no address checking on any write (see RULE12)

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_byte_r <= 1'b0;
      mem_addr_r <= '0;
      mem_wdata_r <= '0;
      src_r <= '0;
      dst_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      if (take && (op_code == PSE_OP_LOAD_IND || op_code == PSE_OP_STORE_IND))
      begin
        mem_req_r <= 1'b1;
        mem_we_r <= op_code == PSE_OP_STORE_IND;
        mem_byte_r <= 1'b0;
        mem_addr_r <= primary_accumulator_r; // see RULE3
        mem_wdata_r <= sel_acc; // see RULE6
      end
      else if (take && op_code == PSE_OP_BLOCK_COPY)
      begin
        src_r <= secondary_accumulator_r; // see RULE8
        dst_r <= primary_accumulator_r; // see RULE8
        cnt_r <= len; // see RULE7
      end
      else if (state_r == PSE_ST_COPY_READ)
      begin
        mem_req_r <= 1'b1;
        mem_byte_r <= 1'b1;
        mem_addr_r <= src_r;
      end
      else if (state_r == PSE_ST_COPY_WAIT && mem_rvalid)
      begin
        mem_req_r <= 1'b1;
        mem_we_r <= 1'b1;
        mem_byte_r <= 1'b1;
        mem_addr_r <= dst_r;
        mem_wdata_r <= {8'h00, mem_rdata[7:0]}; // see RULE10
        src_r <= src_r - 16'h0001; // see RULE9
        dst_r <= dst_r - 16'h0001; // see RULE9
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Handshake outputs

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_ready_r <= 1'b0;
      op_done_r <= 1'b0;
      stopped_r <= 1'b0;
    end
    else
    begin
      op_ready_r <= state_nxt == PSE_ST_IDLE;
      op_done_r <= (take && state_nxt == PSE_ST_IDLE)
        || (state_r == PSE_ST_LOAD_WAIT && mem_rvalid)
        || (state_r == PSE_ST_COPY_WAIT && mem_rvalid && copy_last);
      stopped_r <= state_nxt == PSE_ST_STOPPED; // see RULE18
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // System data area

  pse_sda_mem #(
    .AW(PSE_SDA_AW),
    .DW(DW)
  ) u_sda (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(sys_wr), // see RULE11
    .wr_addr(op_param[DW-1:DW-PSE_SDA_AW]),
    .wr_data(primary_accumulator_r),
    .rd_addr(PSE_SCAN_TIME_WORD),
    .rd_data_r(),
    .scan_time_r(scan_time_r)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks

  chk_add_result: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE15
    take && op_code == PSE_OP_ADD_WORD |=> primary_accumulator_r == $past(primary_accumulator_r)
      + $past(op_param) && $stable(secondary_accumulator_r))
    else $error("add result wrong");

  chk_byte_sext: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE19
    take && op_code == PSE_OP_ADD_BYTE |=>
      primary_accumulator_r == $past(primary_accumulator_r) + sext_byte($past(op_param[7:0])))
    else $error("byte add not sign extended");

  chk_swap_exch: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE16
    take && op_code == PSE_OP_SWAP |=> primary_accumulator_r == $past(secondary_accumulator_r)
      && secondary_accumulator_r == $past(primary_accumulator_r))
    else $error("swap failed");

  chk_stop_enter: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE17
    take && op_code == PSE_OP_STOP |=> stopped_r && !op_ready_r)
    else $error("stop not entered");

  chk_stop_hold: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE18
    stopped_r && !restart |=> stopped_r)
    else $error("stop left without cause");

  chk_ind_addr: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE3
    take && op_code == PSE_OP_STORE_IND |=> mem_req_r && mem_we_r
      && mem_addr_r == $past(primary_accumulator_r) && mem_wdata_r == $past(sel_acc))
    else $error("indirect store address or data wrong");

  chk_load_prim: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE4
    state_r == PSE_ST_LOAD_WAIT && mem_rvalid && !load_sel_sec_r
      |=> primary_accumulator_r == $past(mem_rdata))
    else $error("load did not replace primary");

  chk_copy_dec: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE9
    state_r == PSE_ST_COPY_WAIT && mem_rvalid |=> mem_we_r && mem_addr_r == $past(dst_r)
      && dst_r == $past(dst_r) - 16'h0001 && src_r == $past(src_r) - 16'h0001)
    else $error("copy decrement wrong");

  chk_scan_word: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE11
    sys_wr && op_param[DW-1:DW-PSE_SDA_AW] == PSE_SCAN_TIME_WORD
      |=> scan_time_r == $past(primary_accumulator_r))
    else $error("scan time word not updated");

endmodule : pse_exec

/* File: rtl/pse_pkg.sv */
// Purpose: Shared constants and types for the system operation executor
// Assumes: Single clock mclk at 125 MHz, asynchronous active-low reset
// Notes: Memory is byte addressed, system data area is word indexed, 16-bit words
package pse_pkg;

  localparam int PSE_WORD_W = 16;
  localparam int PSE_LEN_W = 8;
  localparam int PSE_SDA_AW = 8;
  localparam logic [PSE_LEN_W-1:0] PSE_MAX_LEN = 8'hff;
  localparam logic [1:0] PSE_SEL_PRIMARY = 2'h0;
  localparam logic [1:0] PSE_SEL_SECONDARY = 2'h2;
  localparam logic [PSE_SDA_AW-1:0] PSE_SCAN_TIME_WORD = 8'h60;
  localparam int PSE_SCAN_UNIT_MS = 10;
  localparam logic [PSE_WORD_W-1:0] PSE_ACC_RST = 16'h0000;
  localparam logic [PSE_WORD_W-1:0] PSE_SCAN_TIME_RST = 16'h0000;

  typedef enum logic [2:0] {
    PSE_OP_LOAD_IND,
    PSE_OP_STORE_IND,
    PSE_OP_BLOCK_COPY,
    PSE_OP_SYS_STORE,
    PSE_OP_ADD_BYTE,
    PSE_OP_ADD_WORD,
    PSE_OP_SWAP,
    PSE_OP_STOP
  } pse_op_t;

  typedef enum logic [2:0] {
    PSE_ST_IDLE,
    PSE_ST_LOAD_WAIT,
    PSE_ST_COPY_READ,
    PSE_ST_COPY_WAIT,
    PSE_ST_STOPPED
  } pse_state_t;

endpackage : pse_pkg

/* File: rtl/pse_sda_mem.sv */
// Purpose: System data area word store with registered read data
// Assumes: One write and one read port on mclk
// Notes: Word at the scan time index also appears on its own output
module pse_sda_mem
  import pse_pkg::*;
#(
  parameter int AW = PSE_SDA_AW,
  parameter int DW = PSE_WORD_W
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data_r,
  output logic [DW-1:0] scan_time_r
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge mclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_r <= mem[rd_addr];
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scan_time_r <= PSE_SCAN_TIME_RST;
    end
    else if (wr_en && wr_addr == PSE_SCAN_TIME_WORD)
    begin
      scan_time_r <= wr_data;
    end
  end

endmodule : pse_sda_mem

/* File: bench/pse_mem_model.sv */
// Purpose: Program memory model facing the executor
// Assumes: Reads answered lat cycles after the request, lat at least 1
// Notes: Word and byte views are held apart
module pse_mem_model
  import pse_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_byte,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_rvalid,
  output logic [15:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] bmem [logic [15:0]];
  logic [15:0] wmem [logic [15:0]];
  logic [15:0] hold;
  int lat = 1;
  int cnt;
  ////////////////////////////////////////////////////////////////////
  // Writes land unchecked, reads answer late, idle data toggles
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 0;
      mem_rvalid <= 1'b0;
      mem_rdata <= 16'h0000;
    end
    else
    begin
      mem_rvalid <= (cnt == 1);
      mem_rdata <= (cnt == 1) ? hold : ~mem_rdata;
      if (cnt > 0)
        cnt <= cnt - 1;
      if (mem_req && mem_we && mem_byte)
        bmem[mem_addr] = mem_wdata[7:0];
      if (mem_req && mem_we && !mem_byte)
        wmem[mem_addr] = mem_wdata;
      if (mem_req && !mem_we)
      begin
        if (mem_byte)
          hold <= {8'h00, bmem.exists(mem_addr) ? bmem[mem_addr] : 8'h00};
        else
          hold <= wmem.exists(mem_addr) ? wmem[mem_addr] : 16'h0000;
        cnt <= lat;
      end
    end
  end
endmodule : pse_mem_model

/* File: bench/pse_exec_tb.sv */
// Purpose: Self-checking bench for the system operation executor
// Assumes: Memory model answers reads, bench drives the op stream
// Notes: Accumulators are set up through add and swap only
module pse_exec_tb
  import pse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0;
  logic rst_n = 0;
  logic op_valid = 0;
  logic lrb = 0;
  logic run_pin = 0;
  logic start = 0;
  pse_op_t op_code = PSE_OP_SWAP;
  logic [15:0] op_param = 16'h0000;
  logic op_ready_r, op_done_r, mem_req_r, mem_we_r, mem_byte_r, mem_rvalid, stopped_r;
  logic [15:0] mem_addr_r, mem_wdata_r, mem_rdata, pri, sec, scan_time_r;
  logic [15:0] ep = 16'h0000;
  logic [15:0] es = 16'h0000;
  int n_mismatch = 0;
  int check_count = 0;
  always #4 mclk = ~mclk;
  pse_exec pse_exec_i (.mclk(mclk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
    .op_param(op_param), .logic_result_bit(lrb), .mode_run_pin(run_pin),
    .external_start_command(start), .op_ready_r(op_ready_r), .op_done_r(op_done_r),
    .mem_req_r(mem_req_r), .mem_we_r(mem_we_r), .mem_byte_r(mem_byte_r),
    .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r), .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata), .primary_accumulator_r(pri), .secondary_accumulator_r(sec),
    .stopped_r(stopped_r), .scan_time_r(scan_time_r));
  pse_mem_model pse_mem_model_i (.mclk(mclk), .rst_n(rst_n), .mem_req(mem_req_r),
    .mem_we(mem_we_r), .mem_byte(mem_byte_r), .mem_addr(mem_addr_r),
    .mem_wdata(mem_wdata_r), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
  ////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic run(input pse_op_t c, input logic [15:0] p);
    int n;
    n = 0;
    @(posedge mclk);
    op_code <= c;
    op_param <= p;
    op_valid <= 1'b1;
    lrb <= ~lrb;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (op_ready_r !== 1'b1 && n < 3000);
    op_valid <= 1'b0;
    #1;
    while (c != PSE_OP_STOP && op_done_r !== 1'b1 && n < 3000)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 3000)
      chk("op_done_r", 16'h0001, 16'h0000);
    @(posedge mclk);
    #1;
  endtask : run
  task automatic set_acc(input logic [15:0] pv, input logic [15:0] sv);
    logic [15:0] t;
    run(PSE_OP_ADD_WORD, sv - ep);
    run(PSE_OP_SWAP, 16'h0000);
    t = es;
    es = sv;
    ep = t;
    run(PSE_OP_ADD_WORD, pv - ep);
    ep = pv;
    chk("primary", ep, pri);
    chk("secondary", es, sec);
  endtask : set_acc
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_add;
    pse_op_t cs [5] = '{PSE_OP_ADD_BYTE, PSE_OP_ADD_WORD, PSE_OP_ADD_BYTE,
      PSE_OP_ADD_WORD, PSE_OP_ADD_WORD};
    logic [15:0] ps [5] = '{16'h12df, 16'h0100, 16'h3480, 16'h7fff, 16'h7fff};
    set_acc(16'h1020, 16'h5555);
    for (int i = 0; i < 5; i++)
    begin
      run(cs[i], ps[i]);
      ep = ep + ((cs[i] == PSE_OP_ADD_BYTE) ? {{8{ps[i][7]}}, ps[i][7:0]} : ps[i]);
      chk("add primary", ep, pri);
      chk("add secondary", es, sec);
    end
    $display("test add done");
  endtask : t_add
  task automatic t_mem;
    set_acc(16'h6100, 16'hbeef);
    run(PSE_OP_STORE_IND, 16'h0002);
    chk("store secondary", 16'hbeef, pse_mem_model_i.wmem[16'h6100]);
    run(PSE_OP_STORE_IND, 16'h0000);
    chk("store primary", 16'h6100, pse_mem_model_i.wmem[16'h6100]);
    pse_mem_model_i.wmem[16'h6100] = 16'hc3a5;
    pse_mem_model_i.wmem[16'hc3a5] = 16'h1234;
    pse_mem_model_i.lat = 3;
    run(PSE_OP_LOAD_IND, 16'h0000);
    chk("load primary", 16'hc3a5, pri);
    run(PSE_OP_LOAD_IND, 16'h0002);
    chk("load secondary", 16'h1234, sec);
    chk("load keeps primary", 16'hc3a5, pri);
    pse_mem_model_i.lat = 1;
    ep = 16'hc3a5;
    es = 16'h1234;
    $display("test memory done");
  endtask : t_mem
  task automatic t_copy;
    logic [7:0] lens [3] = '{8'h00, 8'h03, 8'hff};
    logic [7:0] e;
    for (int k = 0; k < 3; k++)
    begin
      set_acc(16'h0e90, 16'h10a2);
      for (int i = 0; i < 257; i++)
      begin
        pse_mem_model_i.bmem[16'h10a2 - 16'(i)] = 8'(8'h30 + i);
        pse_mem_model_i.bmem[16'h0e90 - 16'(i)] = 8'haa;
      end
      pse_mem_model_i.lat = (k == 1) ? 3 : 1;
      run(PSE_OP_BLOCK_COPY, {8'h00, lens[k]});
      for (int i = 0; i < 257; i++)
      begin
        e = (i < lens[k]) ? 8'(8'h30 + i) : 8'haa;
        chk("copy byte", {8'h00, e}, {8'h00, pse_mem_model_i.bmem[16'h0e90 - 16'(i)]});
      end
    end
    $display("test copy done");
  endtask : t_copy
  task automatic t_sys;
    set_acc(16'h000a, 16'h0000);
    run(PSE_OP_SYS_STORE, 16'h6000);
    repeat (2) @(posedge mclk);
    chk("scan time", 16'h000a, scan_time_r);
    set_acc(16'h0014, 16'h0000);
    run(PSE_OP_SYS_STORE, 16'h5f00);
    repeat (2) @(posedge mclk);
    chk("scan time kept", 16'h000a, scan_time_r);
    $display("test system word done");
  endtask : t_sys
  task automatic t_stop;
    for (int k = 0; k < 2; k++)
    begin
      run(PSE_OP_STOP, 16'h0000);
      chk("stopped", 16'h0001, {15'h0000, stopped_r});
      @(posedge mclk);
      op_code <= PSE_OP_ADD_WORD;
      op_param <= 16'h0101;
      op_valid <= 1'b1;
      repeat (4) @(posedge mclk);
      op_valid <= 1'b0;
      #1;
      chk("stopped ignores op", ep, pri);
      chk("stopped ready", 16'h0000, {15'h0000, op_ready_r});
      @(posedge mclk);
      if (k == 0)
        start <= 1'b1;
      else
        run_pin <= 1'b1;
      repeat (8) @(posedge mclk);
      start <= 1'b0;
      run_pin <= 1'b0;
      #1;
      chk("stop left", 16'h0000, {15'h0000, stopped_r});
    end
    $display("test stop done");
  endtask : t_stop
  ////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial
  begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk("reset primary", 16'h0000, pri);
    t_add;
    t_mem;
    t_copy;
    t_sys;
    t_stop;
    finish_test;
  end
  initial
  begin
    #500000;
    n_mismatch++;
    finish_test;
  end
endmodule : pse_exec_tb
